// ==== include/status_record_pkg.sv ====
// types and constants shared by the status record framer
package status_record_pkg;

    localparam logic [4:0]  HDR_LEN    = 5'h04;
    localparam logic [4:0]  GEN_LEN    = 5'h18;
    localparam logic [4:0]  PLANE_LEN  = 5'h08;
    localparam logic [4:0]  AXIS_LEN   = 5'h1c;

    localparam logic [2:0]  BLK_HDR    = 3'h0;
    localparam logic [2:0]  BLK_GEN    = 3'h1;
    localparam logic [2:0]  BLK_S      = 3'h2;
    localparam logic [2:0]  BLK_T      = 3'h3;
    localparam logic [2:0]  BLK_A      = 3'h4;
    localparam logic [2:0]  BLK_B      = 3'h5;

    localparam logic [15:0] HDR_MARK   = 16'h8000;
    localparam int          HDR_BIT_I  = 10;
    localparam int          HDR_BIT_T  = 9;
    localparam int          HDR_BIT_S  = 8;
    localparam int          HDR_BIT_B  = 1;
    localparam int          HDR_BIT_A  = 0;

    // bit 0 of a selection is the general block, order follows BLK_*
    typedef struct packed {
        logic b;
        logic a;
        logic t;
        logic s;
        logic i;
    } blk_sel_t;

    typedef struct packed {
        logic     no_arg;
        blk_sel_t sel;
    } query_t;

    typedef struct packed {
        logic program_running;
        logic awaiting_input;
        logic trace_on;
        logic echo_on;
    } gen_status_t;

    typedef struct packed {
        logic latch_occurred;
        logic latch_state;
        logic fwd_limit;
        logic rev_limit;
        logic home_input;
        logic stepper_select_jumper;
    } switch_t;

    // declared from bit 15 down to bit 0
    typedef struct packed {
        logic move_in_progress;
        logic abs_or_rel_mode;
        logic absolute_move_mode;
        logic edge_search;
        logic homing_sequence;
        logic homing_phase1_done;
        logic homing_phase2_or_index_search;
        logic coordinated_mode;
        logic negative_direction;
        logic contour_mode;
        logic slewing;
        logic stopping;
        logic final_decel;
        logic latch_armed;
        logic off_on_error_armed;
        logic motor_off;
    } axis_status_t;

    typedef struct packed {
        logic move_in_progress;
        logic slewing;
        logic stopping;
        logic final_decel;
    } plane_status_t;

    typedef struct packed {
        logic [15:0]     sample;
        logic [9:0][7:0] inputs;
        logic [9:0][7:0] outputs;
        logic [7:0]      error_code;
        gen_status_t     status;
    } gen_blk_t;

    typedef struct packed {
        logic [15:0]        segments;
        plane_status_t      status;
        logic signed [31:0] distance;
    } plane_blk_t;

    typedef struct packed {
        axis_status_t       status;
        switch_t            switches;
        logic [7:0]         stop_code;
        logic signed [31:0] ref_pos;
        logic signed [31:0] motor_pos;
        logic signed [31:0] pos_err;
        logic signed [31:0] aux_pos;
        logic signed [31:0] velocity;
        logic signed [15:0] torque;
        logic signed [15:0] analog;
    } axis_blk_t;

    typedef struct packed {
        gen_blk_t   gen;
        plane_blk_t s;
        plane_blk_t t;
        axis_blk_t  a;
        axis_blk_t  b;
    } record_t;

    typedef enum logic {
        IDLE = 1'b0,
        SEND = 1'b1
    } phase_t;

endpackage

// ==== rtl/status_record_framer.sv ====
// status record framer: serialises a selected status snapshot as bytes
`timescale 1ns/1ns
`default_nettype none

module status_record_framer (
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       query_valid_i,
    input  wire status_record_pkg::query_t  query_i,
    input  wire logic [1:0]                 axes_present_i,
    input  wire status_record_pkg::record_t record_i,
    input  wire logic                       byte_ready_i,
    output logic                            byte_valid_o,
    output logic [7:0]                      byte_o,
    output logic                            byte_last_o,
    output logic [15:0]                     record_len_o
);

    typedef struct packed {
        status_record_pkg::phase_t   phase;
        status_record_pkg::blk_sel_t sel;
        logic [2:0]                  blk;
        logic [4:0]                  off;
        logic [15:0]                 len;
        status_record_pkg::record_t  snap;
        logic                        valid;
        logic                        last;
        logic [7:0]                  data;
    } state_t;

    state_t st;
    state_t next_st;

    function automatic logic [4:0] blk_len(input logic [2:0] blk);
        case (blk)
            status_record_pkg::BLK_HDR: blk_len = status_record_pkg::HDR_LEN;
            status_record_pkg::BLK_GEN: blk_len = status_record_pkg::GEN_LEN;
            status_record_pkg::BLK_S,
            status_record_pkg::BLK_T: blk_len = status_record_pkg::PLANE_LEN;
            default: blk_len = status_record_pkg::AXIS_LEN;
        endcase
    endfunction

    function automatic logic [15:0] rec_len(
        input status_record_pkg::blk_sel_t sel
    );
        logic [15:0] n;
        n = 16'(status_record_pkg::HDR_LEN);
        for (int k = 1; k <= 5; k++)
        begin
            if (sel[k-1])
            begin
                n = n + 16'(blk_len(3'(k)));
            end
        end
        return n;
    endfunction

    // returns BLK_HDR when no later block is selected
    function automatic logic [2:0] next_blk(
        input status_record_pkg::blk_sel_t sel,
        input logic [2:0]                  blk
    );
        logic [2:0] r;
        r = status_record_pkg::BLK_HDR;
        for (int k = 5; k >= 1; k--)
        begin
            if (sel[k-1] && 3'(k) > blk)
            begin
                r = 3'(k);
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] hdr_word(
        input status_record_pkg::blk_sel_t sel
    );
        logic [15:0] w;
        w = status_record_pkg::HDR_MARK;
        w[status_record_pkg::HDR_BIT_I] = sel.i;
        w[status_record_pkg::HDR_BIT_T] = sel.t;
        w[status_record_pkg::HDR_BIT_S] = sel.s;
        w[status_record_pkg::HDR_BIT_B] = sel.b;
        w[status_record_pkg::HDR_BIT_A] = sel.a;
        return w;
    endfunction

    // every multi-byte field leaves low byte first, like the header
    function automatic logic [223:0] blk_image(
        input status_record_pkg::record_t  r,
        input status_record_pkg::blk_sel_t sel,
        input logic [15:0]                 len,
        input logic [2:0]                  blk
    );
        status_record_pkg::plane_blk_t p;
        status_record_pkg::axis_blk_t  a;
        logic [223:0]                  v;
        p = (blk == status_record_pkg::BLK_T) ? r.t : r.s;
        a = (blk == status_record_pkg::BLK_B) ? r.b : r.a;
        case (blk)
            status_record_pkg::BLK_HDR:
                v = {192'h0, len, hdr_word(sel)};
            status_record_pkg::BLK_GEN:
                v = {32'h0, r.gen.status.program_running, 4'h0,
                     r.gen.status.awaiting_input, r.gen.status.trace_on,
                     r.gen.status.echo_on, r.gen.error_code,
                     r.gen.outputs, r.gen.inputs,
                     r.gen.sample};
            status_record_pkg::BLK_S,
            status_record_pkg::BLK_T:
                v = {160'h0, p.distance, p.status.move_in_progress, 9'h0,
                     p.status.slewing, p.status.stopping,
                     p.status.final_decel, 3'h0, p.segments};
            default:
                v = {a.analog, a.torque, a.velocity, a.aux_pos,
                     a.pos_err, a.motor_pos, a.ref_pos, a.stop_code,
                     a.switches.latch_occurred, a.switches.latch_state,
                     2'h0, a.switches.fwd_limit, a.switches.rev_limit,
                     a.switches.home_input,
                     a.switches.stepper_select_jumper,
                     a.status};
        endcase
        return v;
    endfunction

    function automatic logic is_final(
        input status_record_pkg::blk_sel_t sel,
        input logic [2:0]                  blk,
        input logic [4:0]                  off
    );
        return (off + 5'h01 == blk_len(blk)) &&
               (next_blk(sel, blk) == status_record_pkg::BLK_HDR);
    endfunction

    logic                        accept;
    logic                        hs;
    status_record_pkg::blk_sel_t qsel;
    logic [223:0]                image;

    assign accept = (st.phase == status_record_pkg::IDLE) && query_valid_i;
    assign hs     = st.valid && byte_ready_i;

    always_comb
    begin
        next_st = st;
        qsel    = query_i.no_arg ? 5'h1f : query_i.sel;
        qsel.a  = qsel.a & axes_present_i[0];
        qsel.b  = qsel.b & axes_present_i[1];
        case (st.phase)
            status_record_pkg::IDLE:
            begin
                // the snapshot keeps every field of one record coherent
                if (query_valid_i)
                begin
                    next_st.phase = status_record_pkg::SEND;
                    next_st.sel   = qsel;
                    next_st.len   = rec_len(qsel);
                    next_st.snap  = record_i;
                    next_st.blk   = status_record_pkg::BLK_HDR;
                    next_st.off   = 5'h00;
                    next_st.valid = 1'b1;
                    next_st.last  = 1'b0;
                end
            end
            status_record_pkg::SEND:
            begin
                if (hs && st.last)
                begin
                    next_st.phase = status_record_pkg::IDLE;
                    next_st.valid = 1'b0;
                    next_st.last  = 1'b0;
                end
                else if (hs)
                begin
                    if (st.off + 5'h01 == blk_len(st.blk))
                    begin
                        next_st.blk = next_blk(st.sel, st.blk);
                        next_st.off = 5'h00;
                    end
                    else
                    begin
                        next_st.off = st.off + 5'h01;
                    end
                    next_st.last = is_final(st.sel, next_st.blk,
                                            next_st.off);
                end
            end
            default:
            begin
                next_st.phase = status_record_pkg::IDLE;
                next_st.valid = 1'b0;
            end
        endcase
        image        = blk_image(next_st.snap, next_st.sel, next_st.len,
                                 next_st.blk);
        next_st.data = image[{next_st.off, 3'b000} +: 8];
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign byte_valid_o = st.valid;
    assign byte_o       = st.data;
    assign byte_last_o  = st.last;
    assign record_len_o = st.len;

    // helper count of bytes taken in the current record
    logic [7:0] sent;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || accept)
        begin
            sent <= 8'h00;
        end
        else if (hs)
        begin
            sent <= sent + 8'h01;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_header_first;
        accept |=> byte_valid_o && st.blk == status_record_pkg::BLK_HDR
                   && st.off == 5'h00 && !byte_last_o;
    endproperty
    a_header_first: assert property (p_header_first)
        else $error("record does not open with header byte 0");

    property p_only_named;
        byte_valid_o && st.blk != status_record_pkg::BLK_HDR
            |-> st.sel[st.blk - 3'h1];
    endproperty
    a_only_named: assert property (p_only_named)
        else $error("unselected block is being sent");

    property p_no_arg_all;
        accept && query_i.no_arg |=> st.sel.i && st.sel.s && st.sel.t;
    endproperty
    a_no_arg_all: assert property (p_no_arg_all)
        else $error("bare query did not select every block");

    property p_axes_present;
        accept |=> (st.sel.a <= $past(axes_present_i[0]))
                   && (st.sel.b <= $past(axes_present_i[1]));
    endproperty
    a_axes_present: assert property (p_axes_present)
        else $error("axis block selected for a missing axis");

    property p_hdr_flags;
        byte_valid_o && st.blk == status_record_pkg::BLK_HDR
            && st.off == 5'h01 |-> byte_o == {5'h10, st.sel.i,
                                              st.sel.t, st.sel.s};
    endproperty
    a_hdr_flags: assert property (p_hdr_flags)
        else $error("header flag byte is wrong");

    property p_len_count;
        hs && byte_last_o |-> 16'(sent) + 16'h0001 == st.len;
    endproperty
    a_len_count: assert property (p_len_count)
        else $error("bytes sent differ from header count");

    property p_len_le;
        byte_valid_o && st.blk == status_record_pkg::BLK_HDR
            && st.off == 5'h02 && byte_ready_i
            |-> byte_o == st.len[7:0] ##1 byte_o == st.len[15:8];
    endproperty
    a_len_le: assert property (p_len_le)
        else $error("length word not little-endian");

    property p_plane_status;
        byte_valid_o && st.off == 5'h03
            && (st.blk == status_record_pkg::BLK_S
                || st.blk == status_record_pkg::BLK_T)
            |-> byte_o[6:0] == 7'h00;
    endproperty
    a_plane_status: assert property (p_plane_status)
        else $error("unused plane status bits are set");

    property p_gen_status;
        byte_valid_o && st.blk == status_record_pkg::BLK_GEN
            && st.off == 5'h17 |-> byte_o[6:3] == 4'h0
            && byte_o[7] == st.snap.gen.status.program_running;
    endproperty
    a_gen_status: assert property (p_gen_status)
        else $error("general status byte is wrong");

    property p_switch_byte;
        byte_valid_o && st.off == 5'h02
            && st.blk >= status_record_pkg::BLK_A |-> byte_o[5:4] == 2'h0;
    endproperty
    a_switch_byte: assert property (p_switch_byte)
        else $error("unused switch bits are set");

    c_full_record: cover property (accept && query_i.no_arg
        && axes_present_i == 2'h3);
    c_header_only: cover property (hs && byte_last_o
        && st.blk == status_record_pkg::BLK_HDR);
    c_stall: cover property (byte_valid_o && !byte_ready_i ##1
        byte_valid_o && byte_ready_i);
    c_axis_b_end: cover property (hs && byte_last_o
        && st.blk == status_record_pkg::BLK_B);

endmodule

`default_nettype wire

// ==== tb/record_host.sv ====
// host model that drains record bytes, promptly or with random stalls
`timescale 1ns/1ns
`default_nettype none

module record_host (
    input  wire logic clk_i,
    input  wire logic slow_i,
    output logic      byte_ready_o
);
    // ready may drop in mid-field too, so the framer must hold its byte
    initial
    begin
        byte_ready_o = 1'h0;
        forever
        begin
            @(posedge clk_i);
            #1;
            byte_ready_o = slow_i ? ($urandom_range(2) != 0) : 1'h1;
        end
    end
endmodule

`default_nettype wire

// ==== tb/status_record_framer_tb.sv ====
// self-checking bench for the status record framer
`timescale 1ns/1ns
`default_nettype none

module status_record_framer_tb;
    logic                       clk_i = 1'h0;
    logic                       rst_n_i = 1'h0;
    logic                       query_valid_i = 1'h0;
    status_record_pkg::query_t  query_i = '0;
    logic [1:0]                 axes_present_i = 2'h3;
    status_record_pkg::record_t record_i = '0;
    logic                       byte_ready_i;
    logic                       byte_valid_o;
    logic [7:0]                 byte_o;
    logic                       byte_last_o;
    logic [15:0]                record_len_o;
    logic                       slow = 1'h0;
    logic [7:0]                 exp_q[$];
    logic [15:0]                len_q[$];
    logic                       first_byte = 1'h1;
    int                         fail_count = 0;
    int                         cmp_count = 0;
    int                         cycles = 0;

    always #2 clk_i = ~clk_i;

    status_record_framer u_dut (
        .clk_i          (clk_i),
        .rst_n_i        (rst_n_i),
        .query_valid_i  (query_valid_i),
        .query_i        (query_i),
        .axes_present_i (axes_present_i),
        .record_i       (record_i),
        .byte_ready_i   (byte_ready_i),
        .byte_valid_o   (byte_valid_o),
        .byte_o         (byte_o),
        .byte_last_o    (byte_last_o),
        .record_len_o   (record_len_o)
    );

    record_host u_host (
        .clk_i        (clk_i),
        .slow_i       (slow),
        .byte_ready_o (byte_ready_i)
    );

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check_byte(string what, logic [7:0] e, logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask

    task automatic check_flag(string what, logic e, logic g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %s: expected %b seen %b", what, e, g);
        end
    endtask

    task automatic check_len(string what, logic [15:0] e, logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask

    // multi-byte fields leave low byte first
    task automatic push_le(logic [31:0] v, int n);
        for (int k = 0; k < n; k++)
            exp_q.push_back(v[k*8 +: 8]);
    endtask

    task automatic push_plane(status_record_pkg::plane_blk_t p);
        push_le(32'(p.segments), 2);
        push_le({p.status.move_in_progress, 9'h0, p.status.slewing,
                 p.status.stopping, p.status.final_decel, 3'h0}, 2);
        push_le(p.distance, 4);
    endtask

    task automatic push_axis(status_record_pkg::axis_blk_t x);
        push_le(32'(x.status), 2);
        push_le({x.switches.latch_occurred, x.switches.latch_state, 2'h0,
                 x.switches.fwd_limit, x.switches.rev_limit,
                 x.switches.home_input,
                 x.switches.stepper_select_jumper}, 1);
        push_le(32'(x.stop_code), 1);
        push_le(x.ref_pos, 4);
        push_le(x.motor_pos, 4);
        push_le(x.pos_err, 4);
        push_le(x.aux_pos, 4);
        push_le(x.velocity, 4);
        push_le(32'(x.torque), 2);
        push_le(32'(x.analog), 2);
    endtask

    task automatic expect_record(status_record_pkg::query_t q,
                                 logic [1:0] ax,
                                 status_record_pkg::record_t r);
        logic        i, s, t, a, b;
        logic [15:0] fl, len;
        i = q.no_arg | q.sel.i;
        s = q.no_arg | q.sel.s;
        t = q.no_arg | q.sel.t;
        a = (q.no_arg | q.sel.a) & ax[0];
        b = (q.no_arg | q.sel.b) & ax[1];
        fl = {1'h1, 4'h0, i, t, s, 6'h0, b, a};
        len = 16'h4 + 16'h18 * i + 16'h8 * (s + t) + 16'h1c * (a + b);
        push_le(32'(fl), 2);
        push_le(32'(len), 2);
        if (i)
        begin
            push_le(32'(r.gen.sample), 2);
            for (int k = 0; k < 10; k++)
                push_le(32'(r.gen.inputs[k]), 1);
            for (int k = 0; k < 10; k++)
                push_le(32'(r.gen.outputs[k]), 1);
            push_le(32'(r.gen.error_code), 1);
            push_le({r.gen.status.program_running, 4'h0,
                     r.gen.status.awaiting_input, r.gen.status.trace_on,
                     r.gen.status.echo_on}, 1);
        end
        if (s)
            push_plane(r.s);
        if (t)
            push_plane(r.t);
        if (a)
            push_axis(r.a);
        if (b)
            push_axis(r.b);
        len_q.push_back(len);
    endtask

    task automatic run_query(logic na, logic [4:0] sel, logic [1:0] ax,
                             logic refuse);
        status_record_pkg::query_t q;
        int                        n;
        q = {na, sel};
        // the record is 736 bits: 24 words cover every field, sample too
        for (int w = 0; w < 24; w++)
            record_i[w*32 +: 32] = $urandom;
        axes_present_i = ax;
        query_i = q;
        query_valid_i = 1'h1;
        expect_record(q, ax, record_i);
        @(posedge clk_i);
        #1;
        query_valid_i = 1'h0;
        // fresh inputs after accept: the record must be a snapshot
        for (int w = 0; w < 24; w++)
            record_i[w*32 +: 32] = $urandom;
        axes_present_i = ~ax;
        if (refuse)
        begin
            @(posedge clk_i);
            #1;
            query_i = ~q;
            query_valid_i = 1'h1;
            @(posedge clk_i);
            #1;
            query_valid_i = 1'h0;
        end
        n = 0;
        while (exp_q.size() != 0 && n < 2000)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        // a stream that never drains must fail, not slip through idle
        check_len("pending bytes", 16'h0, 16'(exp_q.size()));
        check_flag("idle valid", 1'h0, byte_valid_o);
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fail_count++;
            $display("unexpected timeout: expected done seen running");
            conclude();
        end
    end

    always @(posedge clk_i)
    begin
        if (!rst_n_i)
            first_byte = 1'h1;
        else if (byte_valid_o === 1'h1 && byte_ready_i)
        begin
            if (exp_q.size() == 0)
            begin
                fail_count++;
                $display("unexpected byte: expected none seen %h", byte_o);
            end
            else
            begin
                check_byte("record byte", exp_q.pop_front(), byte_o);
                if (first_byte && len_q.size() != 0)
                    check_len("len", len_q.pop_front(), record_len_o);
                check_flag("last", exp_q.size() == 0, byte_last_o);
                first_byte = (exp_q.size() == 0);
            end
        end
    end

    initial
    begin
        void'($urandom(90123));
        repeat (12) @(posedge clk_i);
        #1;
        rst_n_i = 1'h1;
        check_flag("reset valid", 1'h0, byte_valid_o);
        check_len("reset length", 16'h0, record_len_o);
        for (int k = 0; k < 5; k++)
            run_query(1'h0, 5'(1 << k), 2'h3, 1'h0);
        for (int k = 0; k < 4; k++)
            run_query(1'h1, 5'($urandom), 2'(k), k == 2);
        run_query(1'h0, 5'h18, 2'h0, 1'h0);
        slow = 1'h1;
        for (int k = 0; k < 30; k++)
            run_query(1'($urandom), 5'($urandom), 2'($urandom), 1'($urandom));
        // reset in mid-record must drop the stream at once
        query_i = {1'h1, 5'h0};
        axes_present_i = 2'h3;
        query_valid_i = 1'h1;
        expect_record(query_i, 2'h3, record_i);
        repeat (5) @(posedge clk_i);
        #1;
        query_valid_i = 1'h0;
        rst_n_i = 1'h0;
        @(posedge clk_i);
        #1;
        rst_n_i = 1'h1;
        exp_q.delete();
        len_q.delete();
        check_flag("valid after reset", 1'h0, byte_valid_o);
        check_len("length after reset", 16'h0, record_len_o);
        run_query(1'h0, 5'h1f, 2'h3, 1'h0);
        conclude();
    end
endmodule

`default_nettype wire
